// ### ddc_ctlr.sv
// controller model: selects, gates, seeks, sector count
`timescale 1ns/10ps
module ddc_ctlr (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// drive status
	input wire ddc_pkg::ddc_stat_t stat,
	input wire logic fix_sector,
	input wire logic fix_index,
	// requests
	output ddc_pkg::ddc_ctl_t ctl,
	output logic [7:0] cyl_addr,
	output logic [5:0] rev_cnt
);
	logic half;
	logic [5:0] cnt;
	initial begin
		ctl = '0;
		cyl_addr = 8'h00;
		cnt = 6'h00;
		half = 1'b0;
	end
	// double frequency data keeps flipping
	always @(posedge clk) ctl.wr_data <= !ctl.wr_data;
	always @(posedge clk) begin
		if (fix_index) begin
			cnt <= 6'h01;
			half <= 1'b0;
			rev_cnt <= cnt;
		end else if (fix_sector) begin
			half <= !half;
			cnt <= cnt + {5'h00, half};
		end
	end
	task seek(input logic [7:0] c);
		for (int i = 0; i < 5000 && stat.access_ready !== 1'b1; i++)
			@(posedge clk);
		@(posedge clk);
		cyl_addr <= c;
		ctl.set_cyl <= 1'b1;
		@(posedge clk);
		ctl.set_cyl <= 1'b0;
	endtask
	task sel(input logic [1:0] h);
		@(posedge clk);
		{ctl.sel_fixed, ctl.sel_lower} <= h;
	endtask
	task gate(input logic w, input logic r);
		@(posedge clk);
		ctl.wr_gate <= w;
		ctl.rd_gate <= r;
	endtask
endmodule

// ### ddc_notch.sv
// notch classifier and speed detector for one disc
`timescale 1ns/10ps
module ddc_notch #(
	parameter int NOM_CYC = ddc_pkg::NOTCH_NOM_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// synchronised notch level
	input wire logic notch,
	// pulses and levels
	output logic sector_p,
	output logic index_p,
	output logic speed_ok,
	output logic stopped
);
	localparam logic [31:0] LIM_OK =
		32'(NOM_CYC * 100 / ddc_pkg::SPEED_OK_PCT);
	localparam logic [31:0] LIM_STOP =
		32'(NOM_CYC * 100 / ddc_pkg::STOP_PCT);

	logic notch_d_r, notch_d_nxt;
	logic [31:0] cnt_r, cnt_nxt, last_r, last_nxt;
	logic sector_r, sector_nxt, index_r, index_nxt;
	logic ok_r, ok_nxt, stop_r, stop_nxt;
	logic edge_w, early_w;

	always_comb begin
		edge_w = notch & ~notch_d_r;
		// early notch marks the index
		early_w = ({cnt_r[29:0], 2'b00} < (last_r + {last_r[30:0], 1'b0}));
		notch_d_nxt = notch;
		cnt_nxt = (cnt_r < LIM_STOP) ? cnt_r + 32'h1 : cnt_r;
		last_nxt = last_r;
		sector_nxt = 1'b0;
		index_nxt = 1'b0;
		if (edge_w) begin
			cnt_nxt = 32'h0;
			last_nxt = cnt_r;
			// (RULE7) sector or index
			index_nxt = early_w;
			sector_nxt = ~early_w;
		end
		// (RULE9) speed threshold check
		ok_nxt = (last_r <= LIM_OK) && (cnt_r <= LIM_OK);
		// (RULE10) stopped below fraction
		stop_nxt = (cnt_r >= LIM_STOP);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			notch_d_r <= 1'b0;
			cnt_r <= LIM_STOP;
			last_r <= LIM_STOP;
			sector_r <= 1'b0;
			index_r <= 1'b0;
			ok_r <= 1'b0;
			stop_r <= 1'b1;
		end else begin
			notch_d_r <= notch_d_nxt;
			cnt_r <= cnt_nxt;
			last_r <= last_nxt;
			sector_r <= sector_nxt;
			index_r <= index_nxt;
			ok_r <= ok_nxt;
			stop_r <= stop_nxt;
		end
	end

	assign sector_p = sector_r;
	assign index_p = index_r;
	assign speed_ok = ok_r;
	assign stopped = stop_r;
endmodule

// ### ddc_pkg.sv
// shared constants and types for the disc drive control block
package ddc_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int ERASE_EXT_US = 25;
	localparam int ERASE_EXT_CYC = CLK_HZ / 1_000_000 * ERASE_EXT_US;
	localparam int HOME_MS = 200;
	localparam int SEEK_TO_MS = 200;
	localparam int START_DLY_MS = 180_000;
	localparam int PWR_HOLD_MS = 2000;
	localparam int LAMP_HOLD_MS = 1000;
	localparam int MS_W = 18;
	localparam int SPEED_OK_PCT = 70;
	localparam int STOP_PCT = 2;
	localparam int NOTCH_NOM_CYC = 52083;
	localparam int CELL_CYC = 40;
	localparam int CYL_W = 8;
	localparam int HOME_OFFS = 32;
	localparam int FWD_OFFS = 16;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_CYL = 8'h08;
	localparam logic [CYL_W-1:0] CTRL_RST = 8'h80;
	localparam int STAT_SPEED = 3;
	localparam int STAT_STOP = 4;
	localparam int STAT_READY = 5;
	localparam int STAT_SEEKINC = 6;
	localparam int CYL_PRES_LSB = 0;
	localparam int CYL_CMD_LSB = 8;
	localparam int SW_N = 7;

	typedef enum logic [2:0] {
		S_IDLE, S_SPIN, S_LOAD, S_READY, S_SEEK, S_STOP
	} ddc_state_t;

	// operator switches and supply status, asynchronous
	typedef struct packed {
		logic pwr_back;
		logic pwr_front;
		logic cart_lock;
		logic cart_present;
		logic dc_ok;
	} ddc_sw_t;

	// controller requests
	typedef struct packed {
		logic sel_fixed;
		logic sel_lower;
		logic wr_gate;
		logic wr_data;
		logic rd_gate;
		logic set_cyl;
	} ddc_ctl_t;

	// status to the controller
	typedef struct packed {
		logic ready;
		logic access_ready;
		logic seek_incomplete;
	} ddc_stat_t;
endpackage

// ### ddc_rclk.sv
// read clock synthesizer, retimes raw data to a bit cell clock
`timescale 1ns/10ps
module ddc_rclk #(
	parameter int CELL = ddc_pkg::CELL_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// raw data in, run enable
	input wire logic enable,
	input wire logic raw,
	// retimed outputs
	output logic rd_clk,
	output logic rd_data
);
	localparam logic [7:0] CELL_LAST = 8'(CELL - 1);
	localparam logic [7:0] CELL_MID = 8'(CELL / 2);

	logic [7:0] ph_r, ph_nxt;
	logic raw_d_r, raw_d_nxt, seen_r, seen_nxt;
	logic clk_r, clk_nxt, dat_r, dat_nxt;

	always_comb begin
		raw_d_nxt = raw;
		ph_nxt = (ph_r == CELL_LAST) ? 8'h0 : ph_r + 8'h1;
		seen_nxt = seen_r;
		dat_nxt = dat_r;
		if (raw & ~raw_d_r) begin
			// pull phase so the pulse sits mid cell
			ph_nxt = CELL_MID;
			seen_nxt = 1'b1;
		end else if (ph_r == CELL_LAST) begin
			dat_nxt = seen_r;
			seen_nxt = 1'b0;
		end
		clk_nxt = (ph_nxt < CELL_MID);
		if (!enable) begin
			ph_nxt = 8'h0;
			seen_nxt = 1'b0;
			dat_nxt = 1'b0;
			clk_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ph_r <= 8'h0;
			raw_d_r <= 1'b0;
			seen_r <= 1'b0;
			clk_r <= 1'b0;
			dat_r <= 1'b0;
		end else begin
			ph_r <= ph_nxt;
			raw_d_r <= raw_d_nxt;
			seen_r <= seen_nxt;
			clk_r <= clk_nxt;
			dat_r <= dat_nxt;
		end
	end

	assign rd_clk = clk_r;
	assign rd_data = dat_r;
endmodule

// ### ddc_top.sv
// disc drive control, status, sector, write, read and positioner logic
// How it works
// (RULE1) door unlocks only in unlock, both powers on, dc good, discs stopped
// (RULE2) in lock with power on, door stays locked, motor runs if cartridge
// (RULE3) front power off while locked holds power until heads retract
// (RULE4) power lamp lingers about one second after front power off in lock
// (RULE5) unlock lamp lit exactly while the door is unlocked
// (RULE6) ready after start delays and load, dropped at once when unsafe
// (RULE7) each disc: early notch is index, others are sector pulses
// (RULE8) controller counts every second sector pulse, giving 24 sectors
// (RULE9) speed ok asserted once rotation reaches seventy percent
// (RULE10) spin stopped while rotation is below two percent
// (RULE11) fixed and lower selects decode one of four heads for both paths
// (RULE12) write current follows write data only while write gate is high
// (RULE13) erase on during write gate and 25 us after it
// (RULE14) outer low tracks get the larger write current
// (RULE15) read gate enables amplified selected head into raw data
// (RULE16) read clock synthesized from raw data, read data retimed to it
// (RULE17) positioner error is commanded minus present cylinder normally
// (RULE18) start uses drive home then forward to zero, stop uses home only
// (RULE19) switch and notch inputs pass two flip-flops before use
// (RULE20) no arrival within 200 ms of set cylinder sets seek incomplete
// (RULE21) spin stopped falling starts three minute delay before loading
`timescale 1ns/10ps
module ddc_top #(
	parameter int TICK = ddc_pkg::TICK_CYC,
	parameter int START_MS = ddc_pkg::START_DLY_MS,
	parameter int NOM_CYC = ddc_pkg::NOTCH_NOM_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// switches and notch detectors
	input wire ddc_pkg::ddc_sw_t sw,
	input wire logic notch_fixed,
	input wire logic notch_rem,
	// controller side
	input wire ddc_pkg::ddc_ctl_t ctl,
	input wire logic [ddc_pkg::CYL_W-1:0] cyl_addr,
	output ddc_pkg::ddc_stat_t stat,
	output logic fix_sector,
	output logic fix_index,
	output logic rem_sector,
	output logic rem_index,
	output logic rd_clk,
	output logic rd_data,
	// heads and positioner
	input wire logic [3:0] head_sig,
	input wire logic [ddc_pkg::CYL_W-1:0] present_cyl,
	output logic [3:0] head_sel,
	output logic wr_cur_p,
	output logic wr_cur_n,
	output logic wr_cur_hi,
	output logic erase_on,
	output logic rd_amp_on,
	output logic raw_data,
	output logic signed [ddc_pkg::CYL_W:0] pos_err,
	// power, door and indicators
	output logic door_unlock,
	output logic spin_motor,
	output logic power_hold,
	output logic power_lamp,
	output logic unlock_lamp,
	output logic ready_lamp,
	output logic speed_ok,
	output logic spin_stopped
);
	localparam int CW = ddc_pkg::CYL_W;
	localparam int MW = ddc_pkg::MS_W;

	function automatic logic [3:0] head_dec(input logic fx, input logic lo);
		head_dec = 4'h1 << {fx, lo};
	endfunction

	function automatic logic [MW-1:0] ms(input int v);
		ms = MW'(v);
	endfunction

	// (RULE19) two stage synchronisers
	logic [ddc_pkg::SW_N-1:0] async_w, s1_r, s2_r;
	assign async_w = {sw, notch_fixed, notch_rem};
	genvar g;
	generate
		for (g = 0; g < ddc_pkg::SW_N; g++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					s1_r[g] <= 1'b0;
					s2_r[g] <= 1'b0;
				end else begin
					s1_r[g] <= async_w[g];
					s2_r[g] <= s1_r[g];
				end
			end
		end
	endgenerate

	ddc_pkg::ddc_sw_t ss;
	assign ss = s2_r[ddc_pkg::SW_N-1:2];

	logic ok_f, ok_r2, st_f, st_r2;
	ddc_notch #(.NOM_CYC(NOM_CYC)) u_fix (
		.clk(clk), .rst_b(rst_b), .notch(s2_r[1]),
		.sector_p(fix_sector), .index_p(fix_index),
		.speed_ok(ok_f), .stopped(st_f)
	);
	ddc_notch #(.NOM_CYC(NOM_CYC)) u_rem (
		.clk(clk), .rst_b(rst_b), .notch(s2_r[0]),
		.sector_p(rem_sector), .index_p(rem_index),
		.speed_ok(ok_r2), .stopped(st_r2)
	);
	assign speed_ok = ok_f & ok_r2;
	assign spin_stopped = st_f & st_r2;

	// millisecond enable
	logic [31:0] div_r, div_nxt;
	logic tick_w;
	assign tick_w = (div_r == 32'(TICK - 1));
	always_comb div_nxt = tick_w ? 32'h0 : div_r + 32'h1;

	// sequencer state
	ddc_pkg::ddc_state_t st_r, st_nxt;
	logic [MW-1:0] tmr_r, tmr_nxt, start_r, start_nxt, hold_r, hold_nxt;
	logic [CW-1:0] cmd_r, cmd_nxt, lim_r, lim_nxt;
	logic seekinc_r, seekinc_nxt, stop_d_r, stop_d_nxt;
	logic pwr_on, motor_on, retracted, arrived;

	always_comb begin
		pwr_on = ss.pwr_back & ss.pwr_front;
		motor_on = pwr_on & ss.cart_lock & ss.cart_present & ss.dc_ok;
		arrived = (present_cyl == cmd_r);
		retracted = (st_r == ddc_pkg::S_IDLE) ||
			(st_r == ddc_pkg::S_STOP && tmr_r >= ms(ddc_pkg::HOME_MS));
		st_nxt = st_r;
		cmd_nxt = cmd_r;
		seekinc_nxt = seekinc_r;
		stop_d_nxt = spin_stopped;
		tmr_nxt = (tick_w && tmr_r != '1) ? tmr_r + 1'b1 : tmr_r;
		start_nxt = (tick_w && start_r != '1) ? start_r + 1'b1 : start_r;
		hold_nxt = (tick_w && hold_r != '1) ? hold_r + 1'b1 : hold_r;
		if (ss.pwr_front)
			hold_nxt = '0;
		// (RULE21) restart long delay on spin start
		if (stop_d_r & ~spin_stopped)
			start_nxt = '0;
		unique case (st_r)
			ddc_pkg::S_IDLE: begin
				if (motor_on) begin
					st_nxt = ddc_pkg::S_SPIN;
					tmr_nxt = '0;
					cmd_nxt = '0;
				end
			end
			ddc_pkg::S_SPIN: begin
				if (!spin_stopped && speed_ok &&
					start_r >= ms(START_MS) &&
					tmr_r >= ms(ddc_pkg::HOME_MS))
					st_nxt = ddc_pkg::S_LOAD;
			end
			ddc_pkg::S_LOAD: begin
				if (present_cyl == '0)
					st_nxt = ddc_pkg::S_READY;
			end
			ddc_pkg::S_READY: begin
				if (ctl.set_cyl) begin
					st_nxt = ddc_pkg::S_SEEK;
					cmd_nxt = cyl_addr;
					tmr_nxt = '0;
					seekinc_nxt = 1'b0;
				end
			end
			ddc_pkg::S_SEEK: begin
				if (arrived) begin
					st_nxt = ddc_pkg::S_READY;
				// (RULE20) seek timeout flag
				end else if (tmr_r >= ms(ddc_pkg::SEEK_TO_MS)) begin
					st_nxt = ddc_pkg::S_READY;
					seekinc_nxt = 1'b1;
				end
			end
			ddc_pkg::S_STOP: begin
				if (spin_stopped && tmr_r >= ms(ddc_pkg::HOME_MS))
					st_nxt = ddc_pkg::S_IDLE;
			end
		endcase
		if (!motor_on && st_r != ddc_pkg::S_IDLE &&
			st_r != ddc_pkg::S_STOP) begin
			st_nxt = ddc_pkg::S_STOP;
			tmr_nxt = '0;
		end
		lim_nxt = (wr && addr == ddc_pkg::REG_CTRL) ? wdata[CW-1:0] : lim_r;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_r <= 32'h0;
			st_r <= ddc_pkg::S_IDLE;
			tmr_r <= '0;
			start_r <= '0;
			hold_r <= '1;
			cmd_r <= '0;
			lim_r <= ddc_pkg::CTRL_RST;
			seekinc_r <= 1'b0;
			stop_d_r <= 1'b1;
		end else begin
			div_r <= div_nxt;
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			start_r <= start_nxt;
			hold_r <= hold_nxt;
			cmd_r <= cmd_nxt;
			lim_r <= lim_nxt;
			seekinc_r <= seekinc_nxt;
			stop_d_r <= stop_d_nxt;
		end
	end

	// door, power and lamps
	always_comb begin
		// (RULE1) door release
		door_unlock = pwr_on & ~ss.cart_lock & ss.dc_ok & spin_stopped;
		// (RULE5) unlock lamp
		unlock_lamp = door_unlock;
		// (RULE3) power hold
		power_hold = ss.pwr_back & (ss.pwr_front | (ss.cart_lock &
			~retracted & hold_r < ms(ddc_pkg::PWR_HOLD_MS)));
		// (RULE2) spin motor
		spin_motor = power_hold & ss.cart_lock & ss.cart_present;
		// (RULE4) lamp lingers
		power_lamp = ss.pwr_back & (ss.pwr_front | (ss.cart_lock &
			hold_r < ms(ddc_pkg::LAMP_HOLD_MS)));
		// (RULE6) ready gated by safety
		stat.ready = (st_r == ddc_pkg::S_READY || st_r == ddc_pkg::S_SEEK) &
			ss.dc_ok & speed_ok & motor_on;
		stat.access_ready = stat.ready & (st_r == ddc_pkg::S_READY);
		stat.seek_incomplete = seekinc_r;
		ready_lamp = stat.ready;
	end

	// write, erase, read and positioner datapath
	logic [3:0] hs_r, hs_nxt;
	logic wp_r, wp_nxt, wn_r, wn_nxt, hi_r, hi_nxt, er_r, er_nxt;
	logic amp_r, amp_nxt, raw_r, raw_nxt;
	logic [15:0] ec_r, ec_nxt;
	logic signed [CW:0] pe_r, pe_nxt;
	logic [31:0] rd_r, rd_nxt;

	always_comb begin
		// (RULE11) shared head decode
		hs_nxt = head_dec(ctl.sel_fixed, ctl.sel_lower);
		// (RULE12) bipolar write current
		wp_nxt = ctl.wr_gate & ctl.wr_data;
		wn_nxt = ctl.wr_gate & ~ctl.wr_data;
		// (RULE14) outer tracks high current
		hi_nxt = (present_cyl < lim_r);
		// (RULE13) erase extension
		ec_nxt = ctl.wr_gate ? 16'(ddc_pkg::ERASE_EXT_CYC) :
			(ec_r != 16'h0) ? ec_r - 16'h1 : ec_r;
		er_nxt = ctl.wr_gate | (ec_r != 16'h0);
		// (RULE15) read amplifier and raw data
		amp_nxt = ctl.rd_gate;
		raw_nxt = ctl.rd_gate & |(head_sig & hs_r);
		// (RULE17) normal error source
		pe_nxt = $signed({1'b0, cmd_r}) - $signed({1'b0, present_cyl});
		// (RULE18) start and stop sources
		if (st_r == ddc_pkg::S_STOP ||
			(st_r == ddc_pkg::S_SPIN && tmr_r < ms(ddc_pkg::HOME_MS)))
			pe_nxt = -(CW+1)'(ddc_pkg::HOME_OFFS);
		else if (st_r == ddc_pkg::S_SPIN)
			pe_nxt = '0;
		else if (st_r == ddc_pkg::S_LOAD)
			pe_nxt = (CW+1)'(ddc_pkg::FWD_OFFS);
		rd_nxt = 32'h0;
		if (rd) begin
			unique case (addr)
				ddc_pkg::REG_CTRL: rd_nxt = 32'(lim_r);
				ddc_pkg::REG_STAT: begin
					rd_nxt[2:0] = st_r;
					rd_nxt[ddc_pkg::STAT_SPEED] = speed_ok;
					rd_nxt[ddc_pkg::STAT_STOP] = spin_stopped;
					rd_nxt[ddc_pkg::STAT_READY] = stat.ready;
					rd_nxt[ddc_pkg::STAT_SEEKINC] = seekinc_r;
				end
				ddc_pkg::REG_CYL: begin
					rd_nxt[ddc_pkg::CYL_PRES_LSB +: CW] = present_cyl;
					rd_nxt[ddc_pkg::CYL_CMD_LSB +: CW] = cmd_r;
				end
				default: rd_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hs_r <= 4'h1;
			wp_r <= 1'b0;
			wn_r <= 1'b0;
			hi_r <= 1'b0;
			ec_r <= 16'h0;
			er_r <= 1'b0;
			amp_r <= 1'b0;
			raw_r <= 1'b0;
			pe_r <= '0;
			rd_r <= 32'h0;
		end else begin
			hs_r <= hs_nxt;
			wp_r <= wp_nxt;
			wn_r <= wn_nxt;
			hi_r <= hi_nxt;
			ec_r <= ec_nxt;
			er_r <= er_nxt;
			amp_r <= amp_nxt;
			raw_r <= raw_nxt;
			pe_r <= pe_nxt;
			rd_r <= rd_nxt;
		end
	end

	// (RULE16) read clock and retimed data
	ddc_rclk u_rclk (
		.clk(clk), .rst_b(rst_b), .enable(amp_r), .raw(raw_r),
		.rd_clk(rd_clk), .rd_data(rd_data)
	);

	assign head_sel = hs_r;
	assign wr_cur_p = wp_r;
	assign wr_cur_n = wn_r;
	assign wr_cur_hi = hi_r;
	assign erase_on = er_r;
	assign rd_amp_on = amp_r;
	assign raw_data = raw_r;
	assign pos_err = pe_r;
	assign rdata = rd_r;
endmodule

// ### ddc_top_sva.sv
// assertion checker for the disc drive control block
`timescale 1ns/10ps
module ddc_top_sva (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// inputs
	input wire ddc_pkg::ddc_sw_t sw,
	input wire ddc_pkg::ddc_ctl_t ctl,
	// outputs
	input wire ddc_pkg::ddc_stat_t stat,
	input wire logic [3:0] head_sel,
	input wire logic wr_cur_p,
	input wire logic wr_cur_n,
	input wire logic erase_on,
	input wire logic rd_amp_on,
	input wire logic raw_data,
	input wire logic door_unlock,
	input wire logic unlock_lamp,
	input wire logic speed_ok,
	input wire logic spin_stopped
);
	logic [11:0] gap_r;
	logic [11:0] gap_nxt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// cycles since write gate was last high
	always_comb gap_nxt = ctl.wr_gate ? 12'h000 : gap_r + 12'(gap_r != 12'hFFF);
	always_ff @(posedge clk) gap_r <= rst_b ? gap_nxt : 12'hFFF;
	property p_door;
		door_unlock |-> spin_stopped && $past(sw.pwr_front && sw.pwr_back
			&& sw.dc_ok && !sw.cart_lock, 2);
	endproperty
	a_door: assert property (p_door) else $error("door open unsafe");
	property p_lock;
		$past(sw.cart_lock, 2) |-> !door_unlock;
	endproperty
	a_lock: assert property (p_lock) else $error("door open in lock");
	property p_lamp;
		unlock_lamp == door_unlock;
	endproperty
	a_lamp: assert property (p_lamp) else $error("unlock lamp wrong");
	property p_rdy;
		stat.ready |-> speed_ok && !spin_stopped && $past(sw.dc_ok, 2);
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready while unsafe");
	property p_spd;
		spin_stopped |-> !speed_ok;
	endproperty
	a_spd: assert property (p_spd) else $error("speed and stop both");
	property p_head;
		$past(rst_b) |-> head_sel == 4'h1 << {$past(ctl.sel_fixed),
			$past(ctl.sel_lower)};
	endproperty
	a_head: assert property (p_head) else $error("head decode wrong");
	property p_wcur;
		$past(rst_b) |-> (wr_cur_p || wr_cur_n) == $past(ctl.wr_gate)
			&& !(wr_cur_p && wr_cur_n);
	endproperty
	a_wcur: assert property (p_wcur) else $error("write current");
	property p_erase_on;
		gap_r <= 12'd2400 |-> erase_on;
	endproperty
	a_erase_on: assert property (p_erase_on) else $error("erase off");
	property p_erase_off;
		gap_r > 12'd2600 |-> !erase_on;
	endproperty
	a_erase_off: assert property (p_erase_off) else $error("erase on");
	property p_raw;
		raw_data || rd_amp_on |-> $past(ctl.rd_gate);
	endproperty
	a_raw: assert property (p_raw) else $error("read without gate");
	property p_seek;
		ctl.set_cyl && stat.ready && stat.access_ready |=> !stat.access_ready;
	endproperty
	a_seek: assert property (p_seek) else $error("seek not taken");
	c_rdy: cover property (stat.ready);
	c_sinc: cover property ($rose(stat.seek_incomplete));
	c_erase: cover property ($fell(ctl.wr_gate));
endmodule

bind ddc_top ddc_top_sva ddc_top_sva_i (.*);

// ### ddc_top_tb.sv
// self-checking testbench for the disc drive control block
`timescale 1ns/10ps
module ddc_top_tb;
	logic clk, rst_b, wr, rd, spin, notch_fixed, notch_rem, lc;
	logic [7:0] addr, cyl_addr, present_cyl;
	logic [31:0] wdata, rdata, d;
	logic [3:0] head_sig, head_sel;
	logic wr_cur_p, wr_cur_n, wr_cur_hi, erase_on, rd_amp_on, raw_data;
	logic fix_sector, fix_index, rem_sector, rem_index, rd_clk, rd_data;
	logic door_unlock, spin_motor, power_hold, power_lamp, unlock_lamp;
	logic ready_lamp, speed_ok, spin_stopped;
	logic signed [8:0] pos_err;
	logic [5:0] rev_cnt;
	ddc_pkg::ddc_sw_t sw;
	ddc_pkg::ddc_ctl_t ctl;
	ddc_pkg::ddc_stat_t stat;
	int err_count, compares, cyc, fs, rs, i, a, b;
	ddc_top #(.TICK(10), .START_MS(5), .NOM_CYC(20)) ddc_top_i (.*);
	ddc_ctlr ddc_ctlr_i (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		fs <= fs + fix_sector;
		rs <= rs + rem_sector;
		head_sig <= (cyc % 40 < 20) ? 4'h4 : 4'h0;
		if (cyc == 60000) begin
			err_count++;
			wrap_up;
		end
	end
	// notch wheel: early notch marks index
	always begin
		@(posedge clk);
		if (spin) begin
			for (int k = 0; k < 48; k++) begin
				notch_fixed <= spin;
				notch_rem <= spin;
				repeat (3) @(posedge clk);
				notch_fixed <= 1'b0;
				notch_rem <= 1'b0;
				repeat (k < 2 ? 7 : 17) @(posedge clk);
			end
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	task wrap_up;
		if (err_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task nx(input int n);
		repeat (n) @(negedge clk);
	endtask
	task wreg(input logic [7:0] ad, input logic [31:0] v);
		@(posedge clk);
		addr <= ad;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [7:0] ad);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task t_regs;
		rreg(8'h00);
		chk(d, 32'(ddc_pkg::CTRL_RST));
		wreg(8'h00, 32'h5A);
		rreg(8'h00);
		chk(d, 32'h5A);
		rreg(8'h0C);
		chk(d, 32'h00);
		rreg(8'h04);
		chk(d, 32'h10);
	endtask
	task t_door;
		@(posedge clk);
		sw <= 5'h19;
		nx(5);
		chk(door_unlock, 1);
		chk(unlock_lamp, 1);
		@(posedge clk);
		sw <= 5'h18;
		nx(5);
		chk(door_unlock, 0);
		chk(unlock_lamp, 0);
	endtask
	task t_start;
		@(posedge clk);
		sw <= 5'h1F;
		spin <= 1'b1;
		nx(20);
		chk(door_unlock, 0);
		chk(spin_motor, 1);
		chk({pos_err}, 9'h1E0);
		for (i = 0; i < 9000 && stat.ready !== 1'b1; i++) nx(1);
		chk(i > 1900, 1);
		chk(stat.ready, 1);
		chk(ready_lamp, 1);
		chk(speed_ok, 1);
		chk(spin_stopped, 0);
		for (i = 0; i < 2000 && fix_index !== 1'b1; i++) nx(1);
		a = fs;
		b = rs;
		nx(1);
		for (i = 0; i < 2000 && fix_index !== 1'b1; i++) nx(1);
		chk(fs - a, 47);
		chk(rs - b, 47);
		chk(rem_index, 1);
		chk(rev_cnt, 24);
	endtask
	task t_seek;
		ddc_ctlr_i.seek(8'h05);
		nx(3);
		chk(stat.access_ready, 0);
		chk({pos_err}, 9'h005);
		@(posedge clk);
		present_cyl <= cyl_addr;
		nx(5);
		chk(stat.access_ready, 1);
		rreg(8'h08);
		chk(d, 32'h0505);
		ddc_ctlr_i.seek(8'h09);
		nx(2);
		for (i = 0; i < 3000 && stat.access_ready !== 1'b1; i++) nx(1);
		chk(i > 1900, 1);
		chk(stat.seek_incomplete, 1);
		wreg(8'h04, 32'h00);
		rreg(8'h04);
		chk(d, 32'h6B);
		ddc_ctlr_i.seek(8'h05);
		nx(5);
		chk(stat.seek_incomplete, 0);
	endtask
	task t_write;
		for (a = 0; a < 4; a++) begin
			ddc_ctlr_i.sel(a[1:0]);
			nx(3);
			chk(head_sel, 4'h1 << a);
		end
		wreg(8'h00, 32'h06);
		ddc_ctlr_i.gate(1'b1, 1'b0);
		nx(3);
		chk(wr_cur_p ^ wr_cur_n, 1);
		chk(erase_on, 1);
		chk(wr_cur_hi, 1);
		wreg(8'h00, 32'h05);
		nx(3);
		chk(wr_cur_hi, 0);
		ddc_ctlr_i.gate(1'b0, 1'b0);
		nx(3);
		chk(wr_cur_p | wr_cur_n, 0);
		nx(2480);
		chk(erase_on, 1);
		nx(30);
		chk(erase_on, 0);
	endtask
	task t_read;
		ddc_ctlr_i.sel(2'h2);
		a = 0;
		b = 0;
		for (i = 0; i < 100; i++) begin
			nx(1);
			a += raw_data;
		end
		chk(a, 0);
		ddc_ctlr_i.gate(1'b0, 1'b1);
		lc = rd_clk;
		for (i = 0; i < 200; i++) begin
			nx(1);
			a += raw_data;
			b += (rd_clk !== lc);
			lc = rd_clk;
		end
		chk(rd_amp_on, 1);
		chk(a > 50, 1);
		chk(b > 4, 1);
		chk(rd_data, 1);
		ddc_ctlr_i.gate(1'b0, 1'b0);
	endtask
	task t_stop;
		@(posedge clk);
		sw <= 5'h1B;
		nx(10);
		chk({pos_err}, 9'h1E0);
		chk(door_unlock, 0);
		@(posedge clk);
		spin <= 1'b0;
		for (i = 0; i < 5000 && door_unlock !== 1'b1; i++) nx(1);
		chk(spin_stopped, 1);
		chk(unlock_lamp, 1);
		@(posedge clk);
		sw <= 5'h1F;
		nx(10);
		@(posedge clk);
		sw <= 5'h17;
		nx(10);
		chk(power_hold, 1);
		nx(9000);
		chk(power_hold, 0);
		chk(power_lamp, 1);
		nx(2000);
		chk(power_lamp, 0);
	endtask
	initial begin
		{rst_b, wr, rd, spin, notch_fixed, notch_rem} = 6'h00;
		addr = 8'h00;
		wdata = 32'h0;
		present_cyl = 8'h00;
		head_sig = 4'h0;
		sw = '0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_regs;
		t_door;
		t_start;
		t_seek;
		t_write;
		t_read;
		t_stop;
		wrap_up;
	end
endmodule
